// ---- tpf_pin_model.sv ----
// External count clock source for both count pins.
// Assumes the bench raises run_i only with the pin at rest.
`timescale 1ns/1ps
module tpf_pin_model (
  // Clock and control
  input wire logic clk_sys_i,
  input wire logic run_i,
  input wire logic [3:0] half_i,
  // Count pin
  output logic pin_o
);
  logic [3:0] ph = 4'h0;
  initial pin_o = 1'b0;
  // half period of several clocks; pin still outside frames
  always @(posedge clk_sys_i) begin
    if (!run_i) begin
      ph <= 4'h0;
    end else if (ph == half_i - 4'h1) begin
      ph <= 4'h0;
      pin_o <= !pin_o;
    end else begin
      ph <= ph + 4'h1;
    end
  end
endmodule

// ---- tpf_pkg.sv ----
// Package for the timer prescaler and event flag block.
// Assumes a single 10 MHz system clock and an 8-bit register port.
package tpf_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_EVENT_FLAGS = 8'h16;
  localparam logic [7:0] ADDR_TIMER_CTRL = 8'h23;
  localparam logic [7:0] ADDR_CLOCK_SEL = 8'h24;
  localparam logic [7:0] ADDR_MODE_SEL = 8'h25;
  localparam logic [7:0] FLAGS_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_OVF = 0;
  localparam int BIT_CMPA = 1;
  localparam int BIT_CMPB = 2;
  localparam int BIT_CAPT = 5;
  localparam int BIT_PSR_SHARED = 0;
  localparam int BIT_PSR_ASYNC = 1;
  localparam int BIT_SYNC_HOLD = 7;
  localparam int SEL_B_LSB = 4;

  // ----------------------------------------------------------------
  // Clock select codes and prescaler
  // ----------------------------------------------------------------
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIRECT = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam int PRESC_W = 10;
  localparam logic [PRESC_W-1:0] PRESC_M8 = 10'h007;
  localparam logic [PRESC_W-1:0] PRESC_M64 = 10'h03f;
  localparam logic [PRESC_W-1:0] PRESC_M256 = 10'h0ff;
  localparam logic [PRESC_W-1:0] PRESC_M1024 = 10'h3ff;
  localparam logic [PRESC_W-1:0] PRESC_ONE = 10'h001;

  // Waveform modes relevant to the flags
  localparam logic [3:0] WGM_NORMAL = 4'h0;
  localparam logic [3:0] WGM_CTC_A = 4'h4;
  localparam logic [3:0] WGM_CTC_CAPT = 4'hc;

  // Hardware events presented to the flag register
  typedef struct packed {
    logic capt_pin;
    logic top_reached;
    logic match_a;
    logic match_b;
    logic overflow;
    logic other_ovf_point;
  } tpf_event_type;

  // Vector-taken acknowledges, one per flag
  typedef struct packed {
    logic capt;
    logic cmpb;
    logic cmpa;
    logic ovf;
  } tpf_ack_type;

endpackage

// ---- tpf_props.sv ----
// Checker for the prescaler and flag block.
// Assumes it sees only the ports of tpf_top, one clock domain.
`timescale 1ns/1ps
module tpf_props (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  // Pins and events
  input wire logic ext_count_pin_b_i,
  input wire tpf_pkg::tpf_event_type timer_event_i,
  input wire tpf_pkg::tpf_ack_type vector_ack_i,
  // Watched outputs
  input wire logic tick_a_o,
  input wire logic tick_b_o,
  input wire logic [7:0] timer1_event_flags_o
);
  logic [7:0] sel;
  logic [3:0] mode;
  logic psr;
  logic wr_ctl;
  logic wr_flg;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  assign wr_ctl = reg_wr_i && reg_addr_i == tpf_pkg::ADDR_TIMER_CTRL;
  assign wr_flg = reg_wr_i && reg_addr_i == tpf_pkg::ADDR_EVENT_FLAGS;
  // ------------------------------------------------------------
  // Snooped select, mode and held prescaler reset
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sel <= 8'h00;
      mode <= 4'h0;
      psr <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == tpf_pkg::ADDR_CLOCK_SEL) sel <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == tpf_pkg::ADDR_MODE_SEL) mode <= reg_wdata_i[3:0];
      if (wr_ctl) psr <= reg_wdata_i[0] & reg_wdata_i[7];
    end
  end
  sequence s_direct;
    sel[2:0] == tpf_pkg::CS_DIRECT && !psr && !wr_ctl;
  endsequence
  sequence s_rise;
    $rose(ext_count_pin_b_i) && sel[6:4] == tpf_pkg::CS_EXT_RISE && !psr;
  endsequence
  property p_rsvd; timer1_event_flags_o[7:6] == 2'h0 && timer1_event_flags_o[4:3] == 2'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved flag bit set");
  property p_capt; mode != tpf_pkg::WGM_CTC_CAPT && timer_event_i.capt_pin |=> timer1_event_flags_o[5]; endproperty
  a_capt: assert property (p_capt) else $error("capture flag not set");
  property p_top; mode == tpf_pkg::WGM_CTC_CAPT && timer_event_i.top_reached |=> timer1_event_flags_o[5]; endproperty
  a_top: assert property (p_top) else $error("top did not set capture flag");
  property p_ovf; timer_event_i.overflow && mode inside {4'h0, 4'h4} |=> timer1_event_flags_o[0]; endproperty
  a_ovf: assert property (p_ovf) else $error("overflow flag not set");
  property p_ack; vector_ack_i.ovf && timer_event_i[1:0] == 2'h0 |=> !timer1_event_flags_o[0]; endproperty
  a_ack: assert property (p_ack) else $error("vector did not clear overflow");
  property p_w1c; wr_flg && reg_wdata_i[1] && !timer_event_i.match_a |=> !timer1_event_flags_o[1]; endproperty
  a_w1c: assert property (p_w1c) else $error("write one did not clear");
  property p_direct; s_direct [*2] |=> tick_a_o; endproperty
  a_direct: assert property (p_direct) else $error("direct select missed a tick");
  property p_hold; psr && sel[2:0] == tpf_pkg::CS_DIRECT |=> !tick_a_o; endproperty
  a_hold: assert property (p_hold) else $error("tick while prescaler held");
  property p_stop; sel[2:0] == tpf_pkg::CS_STOP |=> !tick_a_o; endproperty
  a_stop: assert property (p_stop) else $error("tick with no clock selected");
  property p_ext; s_rise |-> ##[2:3] tick_b_o; endproperty
  a_ext: assert property (p_ext) else $error("pin edge tick late");
endmodule
bind tpf_top tpf_props tpf_props_inst (.clk_sys_i, .sys_rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
  .ext_count_pin_b_i, .timer_event_i, .vector_ack_i, .tick_a_o, .tick_b_o, .timer1_event_flags_o);

// ---- tpf_top.sv ----
// Shared timer prescaler, external count pin synchronisers and the
// 16-bit timer's event flag register.
// Assumes counter/compare datapath outside supplies events and consumes ticks.
//
// Summary of operation
// - Capture pin event sets capture flag, bit 5.
// - With capture register as top, top reached sets capture flag instead.
// - Vector execution clears the matching flag.
// - Writing one clears a flag; zero leaves it.
// - Compare A/B flags set on timer tick after counter match.
// - Forced compare strobes never set match flags.
// - Normal and clear-on-match modes set overflow on wrap; others own point.
// - Flag bits 7, 6, 4, 3 read zero.
// - Select 1 ticks every system clock except while the prescaler reset is active, no prescaling.
// - Prescaler taps divide by 8, 64, 256, 1024.
// - Prescaler free-running, shared, separate select per timer.
// - First prescaled tick lands 1 to N+1 cycles after enable.
// - Prescaler reset restarts period for both timers.
// - Count pin sampled each clock through latch and registers.
// - Select 7 counts rising edges, select 6 falling edges.
// - Counter updates 2.5 to 3.5 clocks after pin edge.
// - External pin ticks are never prescaled.
// - Sync hold bit keeps prescaler reset bits as written.
// - Clearing sync hold clears both reset bits together.
// - Shared reset bit resets prescaler, self-clears unless holding.
// - Select 0 gives no tick.
`timescale 1ns/1ps

module tpf_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // External count pins
  input wire logic ext_count_pin_a_i,
  input wire logic ext_count_pin_b_i,
  // Events from the timer datapath
  input wire tpf_pkg::tpf_event_type timer_event_i,
  input wire logic force_compare_a_strobe_i,
  input wire logic force_compare_b_strobe_i,
  input wire tpf_pkg::tpf_ack_type vector_ack_i,
  // Count ticks to the two timers, event flags and async prescaler reset
  output logic tick_a_o,
  output logic tick_b_o,
  output logic [7:0] timer1_event_flags_o,
  output logic async_prescaler_reset_o
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [7:0] timer1_event_flags;
  logic sync_hold_mode;
  logic shared_prescaler_reset;
  logic async_prescaler_reset;
  logic [2:0] count_clock_select_a;
  logic [2:0] count_clock_select_b;
  logic [3:0] waveform_mode_select;
  logic [tpf_pkg::PRESC_W-1:0] presc_cnt;
  logic [2:0] sync_a;
  logic [2:0] sync_b;
  logic wr_flags;
  logic wr_ctrl;
  logic [7:0] next_flags;
  logic [7:0] set_mask;
  logic [7:0] clr_mask;
  logic capt_set;
  logic ovf_set;
  logic [7:0] next_rdata;

  assign wr_flags = reg_wr_i && (reg_addr_i == tpf_pkg::ADDR_EVENT_FLAGS);
  assign wr_ctrl = reg_wr_i && (reg_addr_i == tpf_pkg::ADDR_TIMER_CTRL);

  // ----------------------------------------------------------------
  // Timer control register
  // ----------------------------------------------------------------
  // hold reset bits
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_hold_mode <= 1'b0;
      shared_prescaler_reset <= 1'b0;
      async_prescaler_reset <= 1'b0;
    end else if (wr_ctrl) begin
      sync_hold_mode <= reg_wdata_i[tpf_pkg::BIT_SYNC_HOLD];
      shared_prescaler_reset <= reg_wdata_i[tpf_pkg::BIT_SYNC_HOLD] & reg_wdata_i[tpf_pkg::BIT_PSR_SHARED];
      async_prescaler_reset <= reg_wdata_i[tpf_pkg::BIT_SYNC_HOLD] & reg_wdata_i[tpf_pkg::BIT_PSR_ASYNC];
    end else if (!sync_hold_mode) begin
      shared_prescaler_reset <= 1'b0;
      async_prescaler_reset <= 1'b0;
    end
  end

  // A reset pulse from a write without hold lasts the write cycle itself
  logic psr_pulse;
  assign psr_pulse = wr_ctrl && reg_wdata_i[tpf_pkg::BIT_PSR_SHARED];

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      count_clock_select_a <= tpf_pkg::CS_STOP;
      count_clock_select_b <= tpf_pkg::CS_STOP;
      waveform_mode_select <= tpf_pkg::WGM_NORMAL;
    end else if (reg_wr_i && reg_addr_i == tpf_pkg::ADDR_CLOCK_SEL) begin
      count_clock_select_a <= reg_wdata_i[2:0];
      count_clock_select_b <= reg_wdata_i[tpf_pkg::SEL_B_LSB +: 3];
    end else if (reg_wr_i && reg_addr_i == tpf_pkg::ADDR_MODE_SEL) begin
      waveform_mode_select <= reg_wdata_i[3:0];
    end
  end

  // ----------------------------------------------------------------
  // Shared prescaler
  // ----------------------------------------------------------------
  // free-running shared counter
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      presc_cnt <= '0;
    end else if (psr_pulse || shared_prescaler_reset) begin
      presc_cnt <= '0;
    end else begin
      presc_cnt <= presc_cnt + tpf_pkg::PRESC_ONE;
    end
  end

  logic halted;
  assign halted = psr_pulse || shared_prescaler_reset;

  // ----------------------------------------------------------------
  // External pin synchronisers
  // ----------------------------------------------------------------
  // sample each clock
  // The front latch is modelled by the first flop; stage 2 and 3 feed the edge detector.
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sync_a <= 3'h0;
      sync_b <= 3'h0;
    end else begin
      sync_a <= {sync_a[1:0], ext_count_pin_a_i};
      sync_b <= {sync_b[1:0], ext_count_pin_b_i};
    end
  end

  // ----------------------------------------------------------------
  // Clock select per timer
  // ----------------------------------------------------------------
  function automatic logic sel_tick(input logic [2:0] sel,
                                    input logic [tpf_pkg::PRESC_W-1:0] cnt,
                                    input logic [2:0] syn,
                                    input logic hold);
    logic t;
    t = 1'b0;
    case (sel)
      tpf_pkg::CS_STOP: t = 1'b0;
      tpf_pkg::CS_DIRECT: t = 1'b1;
      tpf_pkg::CS_DIV8: t = (cnt[2:0] == tpf_pkg::PRESC_M8[2:0]);
      tpf_pkg::CS_DIV64: t = (cnt[5:0] == tpf_pkg::PRESC_M64[5:0]);
      tpf_pkg::CS_DIV256: t = (cnt[7:0] == tpf_pkg::PRESC_M256[7:0]);
      tpf_pkg::CS_DIV1024: t = (cnt == tpf_pkg::PRESC_M1024);
      tpf_pkg::CS_EXT_FALL: t = syn[2] & ~syn[1];
      tpf_pkg::CS_EXT_RISE: t = ~syn[2] & syn[1];
      default: t = 1'b0;
    endcase
    sel_tick = t & ~hold;
  endfunction

  // registered tick adds the last cycle of latency
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      tick_a_o <= 1'b0;
      tick_b_o <= 1'b0;
    end else begin
      tick_a_o <= sel_tick(count_clock_select_a, presc_cnt, sync_a, halted);
      tick_b_o <= sel_tick(count_clock_select_b, presc_cnt, sync_b, halted);
    end
  end

  // ----------------------------------------------------------------
  // Event flag register
  // ----------------------------------------------------------------
  // pin capture
  assign capt_set = (waveform_mode_select == tpf_pkg::WGM_CTC_CAPT) ?
                    timer_event_i.top_reached : timer_event_i.capt_pin;
  assign ovf_set = (waveform_mode_select == tpf_pkg::WGM_NORMAL ||
                    waveform_mode_select == tpf_pkg::WGM_CTC_A ||
                    waveform_mode_select == tpf_pkg::WGM_CTC_CAPT) ?
                   timer_event_i.overflow : timer_event_i.other_ovf_point;

  always_comb begin
    set_mask = 8'h00;
    clr_mask = 8'h00;
    set_mask[tpf_pkg::BIT_CAPT] = capt_set;
    set_mask[tpf_pkg::BIT_CMPA] = timer_event_i.match_a & tick_b_o;
    set_mask[tpf_pkg::BIT_CMPB] = timer_event_i.match_b & tick_b_o;
    set_mask[tpf_pkg::BIT_OVF] = ovf_set;
    if (wr_flags) begin
      clr_mask = reg_wdata_i;
    end
    clr_mask[tpf_pkg::BIT_CAPT] = clr_mask[tpf_pkg::BIT_CAPT] | vector_ack_i.capt;
    clr_mask[tpf_pkg::BIT_CMPB] = clr_mask[tpf_pkg::BIT_CMPB] | vector_ack_i.cmpb;
    clr_mask[tpf_pkg::BIT_CMPA] = clr_mask[tpf_pkg::BIT_CMPA] | vector_ack_i.cmpa;
    clr_mask[tpf_pkg::BIT_OVF] = clr_mask[tpf_pkg::BIT_OVF] | vector_ack_i.ovf;
    next_flags = (timer1_event_flags & ~clr_mask) | set_mask;
    next_flags[7:6] = 2'h0;
    next_flags[4:3] = 2'h0;
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      timer1_event_flags <= tpf_pkg::FLAGS_RESET;
      timer1_event_flags_o <= tpf_pkg::FLAGS_RESET;
    end else begin
      timer1_event_flags <= next_flags;
      timer1_event_flags_o <= next_flags;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_comb begin
    case (reg_addr_i)
      tpf_pkg::ADDR_EVENT_FLAGS: next_rdata = timer1_event_flags;
      tpf_pkg::ADDR_TIMER_CTRL: next_rdata = {sync_hold_mode, 5'h00, async_prescaler_reset, shared_prescaler_reset};
      tpf_pkg::ADDR_CLOCK_SEL: next_rdata = {1'b0, count_clock_select_b, 1'b0, count_clock_select_a};
      tpf_pkg::ADDR_MODE_SEL: next_rdata = {4'h0, waveform_mode_select};
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
      async_prescaler_reset_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? next_rdata : 8'h00;
      async_prescaler_reset_o <= async_prescaler_reset;
    end
  end

endmodule

// ---- tpf_top_test.sv ----
// Self-checking bench for tpf_top.
// Assumes the package, checker and pin model are compiled first.
`timescale 1ns/1ps
module tpf_top_test;
  localparam logic [5:0] EVS [4] = '{6'h02, 6'h08, 6'h04, 6'h20};
  localparam logic [3:0] ACKS [4] = '{4'h1, 4'h2, 4'h4, 4'h8};
  localparam logic [7:0] MSK [4] = '{8'h01, 8'h02, 8'h04, 8'h20};
  localparam int DIV [4] = '{8, 64, 256, 1024};
  logic clk_sys_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic [7:0] flags;
  logic pin;
  logic run = 1'b0;
  logic [3:0] half = 4'h2;
  tpf_pkg::tpf_event_type ev = '0;
  tpf_pkg::tpf_ack_type ack = '0;
  logic fa = 1'b0;
  logic fb = 1'b0;
  logic tick_a;
  logic tick_b;
  logic apr;
  int err_total = 0;
  int samples_checked = 0;
  int ca = 0;
  int cb = 0;
  int n;
  int m;
  always #50 clk_sys_i = ~clk_sys_i;
  always @(negedge clk_sys_i) begin
    ca += int'(tick_a);
    cb += int'(tick_b);
  end
  tpf_top tpf_top_inst (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ext_count_pin_a_i(pin), .ext_count_pin_b_i(pin),
    .timer_event_i(ev), .force_compare_a_strobe_i(fa), .force_compare_b_strobe_i(fb), .vector_ack_i(ack),
    .tick_a_o(tick_a), .tick_b_o(tick_b), .timer1_event_flags_o(flags), .async_prescaler_reset_o(apr));
  tpf_pin_model tpf_pin_model_inst (.clk_sys_i(clk_sys_i), .run_i(run), .half_i(half), .pin_o(pin));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    wr <= 1'b0;
  endtask
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk_sys_i);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys_i);
    rd <= 1'b0;
    @(negedge clk_sys_i);
    chk({8'h00, rdata}, {8'h00, e});
  endtask
  task automatic pulse(input logic [5:0] e, input logic [3:0] k);
    @(posedge clk_sys_i);
    ev <= tpf_pkg::tpf_event_type'(e);
    ack <= tpf_pkg::tpf_ack_type'(k);
    @(posedge clk_sys_i);
    ev <= '0;
    ack <= '0;
  endtask
  task automatic win(input int c, input int ea, input int eb);
    @(posedge clk_sys_i);
    ca = 0;
    cb = 0;
    repeat (c) @(posedge clk_sys_i);
    chk(16'(ca), 16'(ea));
    chk(16'(cb), 16'(eb));
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #3000000;
    err_total++;
    complete_run;
  end
  initial begin
    repeat (16) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rc(tpf_pkg::ADDR_EVENT_FLAGS, tpf_pkg::FLAGS_RESET);
    rc(tpf_pkg::ADDR_TIMER_CTRL, tpf_pkg::CTRL_RESET);
    wr_reg(8'h7f, 8'hff);
    rc(8'h7f, 8'h00);
    // Direct select on B so compare matches are not gated away
    wr_reg(tpf_pkg::ADDR_CLOCK_SEL, 8'h11);
    for (int i = 0; i < 4; i++) begin
      pulse(EVS[i], 4'h0);
      rc(tpf_pkg::ADDR_EVENT_FLAGS, MSK[i]);
      chk({8'h00, flags}, {8'h00, MSK[i]});
      wr_reg(tpf_pkg::ADDR_EVENT_FLAGS, ~MSK[i]);
      rc(tpf_pkg::ADDR_EVENT_FLAGS, MSK[i]);
      wr_reg(tpf_pkg::ADDR_EVENT_FLAGS, MSK[i]);
      rc(tpf_pkg::ADDR_EVENT_FLAGS, 8'h00);
      pulse(EVS[i], 4'h0);
      pulse(6'h00, ACKS[i]);
      rc(tpf_pkg::ADDR_EVENT_FLAGS, 8'h00);
    end
    @(posedge clk_sys_i);
    fa <= 1'b1;
    fb <= 1'b1;
    @(posedge clk_sys_i);
    fa <= 1'b0;
    fb <= 1'b0;
    rc(tpf_pkg::ADDR_EVENT_FLAGS, 8'h00);
    // Timer B stopped: a match without a timer tick must not set a flag
    wr_reg(tpf_pkg::ADDR_CLOCK_SEL, 8'h01);
    pulse(6'h0c, 4'h0);
    rc(tpf_pkg::ADDR_EVENT_FLAGS, 8'h00);
    wr_reg(tpf_pkg::ADDR_CLOCK_SEL, 8'h11);
    $display("test flags done");
    wr_reg(tpf_pkg::ADDR_MODE_SEL, {4'h0, tpf_pkg::WGM_CTC_CAPT});
    pulse(6'h20, 4'h0);
    rc(tpf_pkg::ADDR_EVENT_FLAGS, 8'h00);
    pulse(6'h10, 4'h0);
    rc(tpf_pkg::ADDR_EVENT_FLAGS, 8'h20);
    wr_reg(tpf_pkg::ADDR_MODE_SEL, 8'h02);
    wr_reg(tpf_pkg::ADDR_EVENT_FLAGS, 8'hff);
    pulse(6'h02, 4'h0);
    rc(tpf_pkg::ADDR_EVENT_FLAGS, 8'h00);
    pulse(6'h01, 4'h0);
    rc(tpf_pkg::ADDR_EVENT_FLAGS, 8'h01);
    wr_reg(tpf_pkg::ADDR_MODE_SEL, {4'h0, tpf_pkg::WGM_CTC_A});
    // Overflow and its write-one clear in one cycle
    @(posedge clk_sys_i);
    ev <= tpf_pkg::tpf_event_type'(6'h02);
    addr <= tpf_pkg::ADDR_EVENT_FLAGS;
    wdata <= 8'h01;
    wr <= 1'b1;
    @(posedge clk_sys_i);
    ev <= '0;
    wr <= 1'b0;
    rc(tpf_pkg::ADDR_EVENT_FLAGS, 8'h01);
    $display("test modes done");
    win(20, 20, 20);
    for (int i = 0; i < 4; i++) begin
      wr_reg(tpf_pkg::ADDR_CLOCK_SEL, {1'b0, tpf_pkg::CS_DIV8, 1'b0, 3'(i + 2)});
      win(2048, 2048 / DIV[i], 256);
    end
    wr_reg(tpf_pkg::ADDR_CLOCK_SEL, 8'h22);
    // Two resets at different prescaler phases must give the same latency
    for (int k = 0; k < 2; k++) begin
      repeat (k * 3) @(posedge clk_sys_i);
      wr_reg(tpf_pkg::ADDR_TIMER_CTRL, 8'h01);
      n = 0;
      do begin
        @(negedge clk_sys_i);
        n++;
      end while (tick_a !== 1'b1 && n < 20);
      chk({15'h0, tick_b}, 16'h0001);
      chk({15'h0, n >= 1 && n <= 9}, 16'h0001);
      if (k == 0) begin
        m = n;
      end else begin
        chk(16'(n), 16'(m));
      end
    end
    rc(tpf_pkg::ADDR_TIMER_CTRL, 8'h00);
    wr_reg(tpf_pkg::ADDR_TIMER_CTRL, 8'h83);
    rc(tpf_pkg::ADDR_TIMER_CTRL, 8'h83);
    chk({15'h0, apr}, 16'h0001);
    win(64, 0, 0);
    wr_reg(tpf_pkg::ADDR_TIMER_CTRL, 8'h00);
    rc(tpf_pkg::ADDR_TIMER_CTRL, 8'h00);
    chk({15'h0, apr}, 16'h0000);
    win(64, 8, 8);
    wr_reg(tpf_pkg::ADDR_CLOCK_SEL, 8'h00);
    win(64, 0, 0);
    $display("test ticks done");
    for (int j = 0; j < 2; j++) begin
      // select changed only with the pin at rest
      wr_reg(tpf_pkg::ADDR_CLOCK_SEL, j == 0 ? 8'h67 : 8'h76);
      @(posedge clk_sys_i);
      half <= j == 0 ? 4'h2 : 4'h5;
      ca = 0;
      cb = 0;
      run <= 1'b1;
      repeat (j == 0 ? 20 : 50) @(posedge clk_sys_i);
      run <= 1'b0;
      repeat (8) @(posedge clk_sys_i);
      chk(16'(ca), 16'h0005);
      chk(16'(cb), 16'h0005);
    end
    $display("test ext done");
    complete_run;
  end
endmodule
